// *** bench/rcc_host.sv ***
`timescale 1ns/1ps
module rcc_host (
   input wire logic mclk,
   input wire logic desel,
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd
);
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // idle bus shows the inverse of the last value
   task automatic wr_raw(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      while (desel === 1'b1) @(posedge mclk);
      wr_raw(a, d);
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      addr <= ~a;
   endtask
endmodule // rcc_host

// *** bench/rtc_calibration_and_output_control_bench.sv ***
`timescale 1ns/1ps
module rtc_calibration_and_output_control_bench;
   typedef struct {logic [7:0] a; logic [7:0] e; logic [7:0] m;} rcc_note_type;
   localparam int OSC_P = 4;
   localparam int TEST_GAP = OSC_P * rcc_pkg::TEST_HALF;
   localparam int DIV_GAP = OSC_P * rcc_pkg::CAL_STAGE_DIV;
   localparam int NO_EDGE = 1500;
   localparam logic [3:0] STP = 4'b1010;
   localparam logic [3:0] SEL = 4'b1100;
   localparam logic [3:0] MS = 4'b1011;
   localparam logic [3:0] BL = 4'b0101;
   localparam logic [3:0] WK = 4'b0001;
   localparam int DCNT [4] = '{50, 30, 10, 10};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic osc_tick = 1'b0;
   logic power_up = 1'b0;
   logic power_down = 1'b0;
   logic main_supply_ok = 1'b1;
   logic battery_low_raw = 1'b0;
   logic century_rollover = 1'b0;
   logic minute_tick = 1'b0;
   logic [5:0] minute_count = 6'h00;
   logic irq_pending = 1'b0;
   logic wd_timeout = 1'b0;
   logic rd_seen = 1'b0;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic wr;
   logic rd;
   logic pin_o;
   logic pin_oe;
   logic deselected;
   logic div256_tick;
   logic second_tick;
   logic [7:0] d;
   int err_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int gap;
   int t0;
   rcc_note_type cur;
   rcc_note_type note_q[$];
   rcc_top #(.DESEL_SLOW(50), .DESEL_STOP(30), .DESEL_FAST(10),
      .SEC_PER_CHECK(4)) DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .osc_tick(osc_tick),
      .power_up(power_up), .battery_retained(1'b0),
      .power_down(power_down), .main_supply_ok(main_supply_ok),
      .battery_low_raw(battery_low_raw),
      .century_rollover(century_rollover), .minute_tick(minute_tick),
      .minute_count(minute_count), .irq_pending(irq_pending),
      .wd_timeout(wd_timeout), .shared_irq_test_pin_o(pin_o),
      .shared_irq_test_pin_oe(pin_oe), .deselected(deselected),
      .div256_tick(div256_tick), .second_tick(second_tick));
   rcc_host host (.mclk(mclk), .desel(deselected), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd));
   ////////////////////////////////////////////////////////////////////
   initial forever #5 mclk = ~mclk;
   // fast oscillator stand-in keeps the run short
   initial forever begin
      repeat (2) @(posedge mclk);
      osc_tick <= ~osc_tick;
   end
   always @(posedge mclk) begin
      rd_seen <= rd;
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         wrap_up();
      end
   end
   always @(negedge mclk) begin
      if (rd_seen === 1'b1 && note_q.size() > 0) begin
         cur = note_q.pop_front();
         cmp_byte(cur.a, cur.e & cur.m, rdata & cur.m);
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic cmp_byte(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH reg %h expected %h seen %h", a, e, g);
      end
   endtask
   task automatic cmp_int(input string nm, input int e, input int g);
      num_checks++;
      if (g != e) begin
         err_count++;
         $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [7:0] e,
      input logic [7:0] m);
      note_q.push_back('{a, e, m});
      host.rd_reg(a);
   endtask
   // cycles between two pin edges (sel 0) or two stage pulses (sel 1)
   task automatic gap_of(input bit sel, output int n);
      logic p;
      logic hit;
      @(negedge mclk);
      p = pin_oe;
      for (int ph = 0; ph < 2; ph++) begin
         n = 0;
         do begin
            @(negedge mclk);
            n++;
            hit = sel ? div256_tick : (pin_oe !== p);
            p = pin_oe;
         end while (hit !== 1'b1 && n < NO_EDGE);
      end
   endtask
   task automatic pulse_minute(input logic [5:0] m);
      @(posedge mclk);
      minute_count <= m;
      minute_tick <= 1'b1;
      @(posedge mclk);
      minute_tick <= 1'b0;
   endtask
   task automatic pulse_century();
      @(posedge mclk);
      century_rollover <= 1'b1;
      @(posedge mclk);
      century_rollover <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hadeabaea));
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      chk_rd(rcc_pkg::ADDR_CONTROL, 8'h80, 8'hff);
      chk_rd(rcc_pkg::ADDR_FLAGS, 8'h40, 8'h40);
      chk_rd(rcc_pkg::ADDR_HOURS, 8'h00, 8'h80);
      chk_rd(rcc_pkg::ADDR_SECONDS, 8'h80, 8'h80);
      chk_rd(rcc_pkg::ADDR_WATCHDOG, 8'h00, 8'hff);
      chk_rd(rcc_pkg::ADDR_ALARM_MONTH, 8'h00, 8'hc0);
      chk_rd(8'h55, 8'h00, 8'hff);
      repeat (2) @(negedge mclk);
      cmp_bit("pin_oe", 1'b0, pin_oe);
      host.wr_reg(rcc_pkg::ADDR_CONTROL, 8'h00);
      repeat (3) @(negedge mclk);
      cmp_bit("pin_oe", 1'b1, pin_oe);
      d = 8'($urandom);
      host.wr_reg(rcc_pkg::ADDR_CONTROL, d);
      chk_rd(rcc_pkg::ADDR_CONTROL, d, 8'hff);
      host.wr_reg(rcc_pkg::ADDR_SECONDS, 8'h00);
      host.wr_reg(rcc_pkg::ADDR_ALARM_MONTH, 8'h00);
      host.wr_reg(rcc_pkg::ADDR_WATCHDOG, 8'h00);
      host.wr_reg(rcc_pkg::ADDR_CONTROL, 8'h40);
      gap_of(1'b0, gap);
      cmp_int("test_gap", TEST_GAP, gap);
      d = 8'($urandom) | 8'h40;
      host.wr_reg(rcc_pkg::ADDR_CONTROL, d);
      gap_of(1'b0, gap);
      cmp_int("test_gap", TEST_GAP, gap);
      host.wr_reg(rcc_pkg::ADDR_WATCHDOG, 8'h81);
      wd_timeout <= 1'b1;
      gap_of(1'b0, gap);
      cmp_int("test_gap", TEST_GAP, gap);
      host.wr_reg(rcc_pkg::ADDR_WATCHDOG, 8'h01);
      gap_of(1'b0, gap);
      cmp_int("no_edge", NO_EDGE, gap);
      cmp_bit("pin_oe", 1'b1, pin_oe);
      @(posedge mclk);
      wd_timeout <= 1'b0;
      host.wr_reg(rcc_pkg::ADDR_WATCHDOG, 8'h00);
      irq_pending <= 1'b1;
      gap_of(1'b0, gap);
      cmp_int("no_edge", NO_EDGE, gap);
      cmp_bit("pin_oe", 1'b1, pin_oe);
      @(posedge mclk);
      irq_pending <= 1'b0;
      power_down <= 1'b1;
      repeat (8) @(posedge mclk);
      power_down <= 1'b0;
      chk_rd(rcc_pkg::ADDR_CONTROL, 8'h00, 8'h40);
      host.wr_reg(rcc_pkg::ADDR_CENTURY, 8'h80);
      pulse_century();
      chk_rd(rcc_pkg::ADDR_CENTURY, 8'hc0, 8'hc0);
      host.wr_reg(rcc_pkg::ADDR_CENTURY, 8'h40);
      pulse_century();
      chk_rd(rcc_pkg::ADDR_CENTURY, 8'h40, 8'hc0);
      host.wr_reg(rcc_pkg::ADDR_CONTROL, 8'h80);
      pulse_minute(6'($urandom));
      gap_of(1'b1, gap);
      cmp_int("stage_gap", DIV_GAP, gap);
      host.wr_reg(rcc_pkg::ADDR_CONTROL, 8'h85);
      pulse_minute(6'd40);
      gap_of(1'b1, gap);
      cmp_int("stage_gap", DIV_GAP, gap);
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         main_supply_ok <= MS[i];
         battery_low_raw <= BL[i];
         host.wr_reg(rcc_pkg::ADDR_SECONDS, {STP[i], 7'h00});
         host.wr_reg(rcc_pkg::ADDR_HOURS, {SEL[i], 7'h00});
         host.wr_reg(rcc_pkg::ADDR_ALARM_MONTH, 8'hc0);
         host.wr_reg(rcc_pkg::ADDR_WATCHDOG, 8'h81);
         host.wr_reg(rcc_pkg::ADDR_CONTROL, 8'hc0);
         power_up <= 1'b1;
         for (int k = 0; k < 20 && deselected !== 1'b1; k++) @(negedge mclk);
         t0 = cyc;
         host.wr_raw(rcc_pkg::ADDR_CONTROL, 8'h1f);
         for (int k = 0; k < 200 && deselected === 1'b1; k++) @(negedge mclk);
         cmp_int("deselect", DCNT[i], cyc - t0);
         @(posedge mclk);
         power_up <= 1'b0;
         chk_rd(rcc_pkg::ADDR_CONTROL, 8'h80, 8'hff);
         chk_rd(rcc_pkg::ADDR_SECONDS, {STP[i], 7'h00}, 8'h80);
         chk_rd(rcc_pkg::ADDR_HOURS, {SEL[i], 7'h00}, 8'h80);
         chk_rd(rcc_pkg::ADDR_ALARM_MONTH, 8'h00, 8'hc0);
         chk_rd(rcc_pkg::ADDR_WATCHDOG, 8'h00, 8'hff);
         chk_rd(rcc_pkg::ADDR_FLAGS, {3'b010, WK[i], 4'h0}, 8'h50);
      end
      repeat (2) @(posedge mclk);
      wrap_up();
   end
endmodule // rtc_calibration_and_output_control_bench

// *** rtl/rcc_pkg.sv ***
package rcc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_SECONDS = 8'h01;
   localparam logic [7:0] ADDR_CENTURY = 8'h03;
   localparam logic [7:0] ADDR_HOURS = 8'h04;
   localparam logic [7:0] ADDR_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_WATCHDOG = 8'h09;
   localparam logic [7:0] ADDR_ALARM_MONTH = 8'h0a;
   localparam logic [7:0] ADDR_FLAGS = 8'h0f;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   // field positions
   localparam int CAL_MAG_LSB = 0;
   localparam int CAL_MAG_W = 5;
   localparam int CAL_SIGN_BIT = 5;
   localparam int FREQ_TEST_BIT = 6;
   localparam int OUT_LEVEL_BIT = 7;
   localparam int STOP_BIT = 7;
   localparam int CENT_EN_BIT = 7;
   localparam int CENT_FLAG_BIT = 6;
   localparam int DESEL_SEL_BIT = 7;
   localparam int HALT_BIT = 6;
   localparam int ALARM_EN_BIT = 7;
   localparam int BACKUP_ALARM_BIT = 6;
   localparam int SQW_EN_BIT = 6;
   localparam int WD_STEER_BIT = 7;
   localparam int BATT_WEAK_BIT = 4;
   // reset values
   localparam logic [7:0] CONTROL_INIT = 8'h80;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // calibration sequencer figures (oscillator cycles)
   localparam int CAL_STAGE_DIV = 256;
   localparam int CAL_SHORTEN = 128;
   localparam int CAL_LENGTHEN = 256;
   localparam int CAL_CYCLE_MIN = 64;
   localparam int OSC_PER_SEC = 32768;
   localparam int SEC_PER_MIN = 60;
   localparam int TEST_HZ = 512;
   localparam int TEST_HALF = OSC_PER_SEC / (2 * TEST_HZ);
   // deselect figures
   localparam int CLK_MHZ = 100;
   localparam int DESEL_SLOW_MS = 96;
   localparam int DESEL_STOP_MS = 40;
   localparam int DESEL_FAST_US = 50;
   localparam int DESEL_SLOW_CYC = DESEL_SLOW_MS * 1000 * CLK_MHZ;
   localparam int DESEL_STOP_CYC = DESEL_STOP_MS * 1000 * CLK_MHZ;
   localparam int DESEL_FAST_CYC = DESEL_FAST_US * CLK_MHZ;
   localparam int BATT_CHECK_HOURS = 24;
   localparam int BATT_CHECK_SEC = BATT_CHECK_HOURS * 3600;
endpackage

// *** rtl/rcc_top.sv ***
`timescale 1ns/1ps
module rcc_top #(
   parameter int DESEL_SLOW = rcc_pkg::DESEL_SLOW_CYC,
   parameter int DESEL_STOP = rcc_pkg::DESEL_STOP_CYC,
   parameter int DESEL_FAST = rcc_pkg::DESEL_FAST_CYC,
   parameter int SEC_PER_CHECK = rcc_pkg::BATT_CHECK_SEC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic osc_tick,
   input wire logic power_up,
   input wire logic battery_retained,
   input wire logic power_down,
   input wire logic main_supply_ok,
   input wire logic battery_low_raw,
   input wire logic century_rollover,
   input wire logic minute_tick,
   input wire logic [5:0] minute_count,
   input wire logic irq_pending,
   input wire logic wd_timeout,
   output logic shared_irq_test_pin_o,
   output logic shared_irq_test_pin_oe,
   output logic deselected,
   output logic div256_tick,
   output logic second_tick
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [1:0] osc_s, pu_s, pd_s, ms_s, bl_s;
   logic osc_prev;
   logic osc_edge;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         osc_s <= 2'h0;
         pu_s <= 2'h0;
         pd_s <= 2'h0;
         ms_s <= 2'h0;
         bl_s <= 2'h0;
      end else begin
         osc_s <= {osc_s[0], osc_tick};
         pu_s <= {pu_s[0], power_up};
         pd_s <= {pd_s[0], power_down};
         ms_s <= {ms_s[0], main_supply_ok};
         bl_s <= {bl_s[0], battery_low_raw};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         osc_prev <= 1'b0;
      end else begin
         osc_prev <= osc_s[1];
      end
   end
   assign osc_edge = osc_s[1] & ~osc_prev;

   logic pu_prev, pd_prev;
   logic pu_edge, pd_edge;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pu_prev <= 1'b0;
         pd_prev <= 1'b0;
      end else begin
         pu_prev <= pu_s[1];
         pd_prev <= pd_s[1];
      end
   end
   assign pu_edge = pu_s[1] & ~pu_prev;
   assign pd_edge = pd_s[1] & ~pd_prev;

   ////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] control;
   logic [7:0] watchdog;
   logic stop_bit, halt_bit, desel_sel, alarm_en, backup_alarm, sqw_en;
   logic cent_en, cent_flag, batt_weak;
   logic desel_busy;
   logic wr_ok;

   assign wr_ok = wr & ~desel_busy;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         control <= rcc_pkg::CONTROL_INIT;
      end else if (pu_edge) begin
         control[rcc_pkg::FREQ_TEST_BIT] <= 1'b0;
      end else if (pd_edge) begin
         control[rcc_pkg::FREQ_TEST_BIT] <= 1'b0;
      end else if (wr_ok && addr == rcc_pkg::ADDR_CONTROL) begin
         control <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || pu_edge) begin
         watchdog <= rcc_pkg::ZERO_BYTE;
      end else if (wr_ok && addr == rcc_pkg::ADDR_WATCHDOG) begin
         watchdog <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stop_bit <= 1'b1;
         halt_bit <= 1'b1;
         desel_sel <= 1'b0;
         alarm_en <= 1'b0;
         backup_alarm <= 1'b0;
         sqw_en <= 1'b0;
      end else if (pu_edge) begin
         halt_bit <= 1'b1;
         alarm_en <= 1'b0;
         backup_alarm <= 1'b0;
         sqw_en <= 1'b0;
      end else if (wr_ok) begin
         if (addr == rcc_pkg::ADDR_SECONDS) begin
            stop_bit <= wdata[rcc_pkg::STOP_BIT];
         end
         if (addr == rcc_pkg::ADDR_HOURS) begin
            desel_sel <= wdata[rcc_pkg::DESEL_SEL_BIT];
         end
         if (addr == rcc_pkg::ADDR_ALARM_MONTH) begin
            alarm_en <= wdata[rcc_pkg::ALARM_EN_BIT];
            backup_alarm <= wdata[rcc_pkg::BACKUP_ALARM_BIT];
            sqw_en <= wdata[rcc_pkg::SQW_EN_BIT];
         end
         if (addr == rcc_pkg::ADDR_FLAGS) begin
            halt_bit <= wdata[rcc_pkg::HALT_BIT];
         end
      end
   end

   // century flag: rollover toggle wins over a write
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cent_en <= 1'b0;
         cent_flag <= 1'b0;
      end else begin
         if (wr_ok && addr == rcc_pkg::ADDR_CENTURY) begin
            cent_en <= wdata[rcc_pkg::CENT_EN_BIT];
            cent_flag <= wdata[rcc_pkg::CENT_FLAG_BIT];
         end
         if (century_rollover && cent_en) begin
            cent_flag <= ~cent_flag;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata <= rcc_pkg::ZERO_BYTE;
      end else if (rd) begin
         unique case (addr)
            rcc_pkg::ADDR_CONTROL: rdata <= control;
            rcc_pkg::ADDR_WATCHDOG: rdata <= watchdog;
            rcc_pkg::ADDR_CENTURY: rdata <= {cent_en, cent_flag, 6'h00};
            rcc_pkg::ADDR_HOURS: rdata <= {desel_sel, 7'h00};
            rcc_pkg::ADDR_SECONDS: rdata <= {stop_bit, 7'h00};
            rcc_pkg::ADDR_ALARM_MONTH: begin
               rdata <= {alarm_en, backup_alarm, sqw_en, 5'h00};
            end
            rcc_pkg::ADDR_FLAGS: begin
               rdata <= {1'b0, halt_bit, 1'b0, batt_weak, 4'h0};
            end
            rcc_pkg::ADDR_STATUS: rdata <= {7'h00, desel_busy};
            default: rdata <= rcc_pkg::ZERO_BYTE;
         endcase
      end else begin
         rdata <= rcc_pkg::ZERO_BYTE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // deselect timer after power-up
   logic [31:0] desel_cnt;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         desel_busy <= 1'b0;
         desel_cnt <= 32'h0;
      end else if (pu_edge) begin
         desel_busy <= 1'b1;
         if (desel_sel) begin
            desel_cnt <= 32'(DESEL_FAST);
         end else if (stop_bit) begin
            desel_cnt <= 32'(DESEL_STOP);
         end else begin
            desel_cnt <= 32'(DESEL_SLOW);
         end
      end else if (desel_busy) begin
         if (desel_cnt <= 32'h1) begin
            desel_busy <= 1'b0;
         end
         desel_cnt <= desel_cnt - 32'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         deselected <= 1'b0;
      end else begin
         // drops with the busy flag so both span the same count
         deselected <= pu_edge | (desel_busy & (desel_cnt > 32'h1));
      end
   end

   ////////////////////////////////////////////////////////////////////
   // calibrated divider chain
   localparam int PRE_W = 8;
   localparam int SEC_W = 8;
   localparam int MIN_W = 6;
   logic [PRE_W-1:0] pre_cnt;
   logic [SEC_W-1:0] stage_cnt;
   logic [MIN_W-1:0] sec_in_min;
   logic min_armed, corr_now, eligible;
   logic [4:0] cal_mag;
   logic cal_pos;

   assign cal_mag = control[rcc_pkg::CAL_MAG_LSB +: rcc_pkg::CAL_MAG_W];
   assign cal_pos = control[rcc_pkg::CAL_SIGN_BIT];
   assign eligible = {1'b0, minute_count} < {1'b0, cal_mag, 1'b0};

   // arm once at minute start, fire on first second
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         min_armed <= 1'b0;
      end else if (minute_tick) begin
         min_armed <= eligible;
      end else if (second_tick) begin
         min_armed <= 1'b0;
      end
   end
   assign corr_now = min_armed & (stage_cnt == 8'hff);

   // +256 by doubling one stage pulse, -128 by skipping half a stage
   logic [PRE_W-1:0] pre_top;
   always_comb begin
      pre_top = PRE_W'(rcc_pkg::CAL_STAGE_DIV - 1);
      if (corr_now && !cal_pos) begin
         pre_top = PRE_W'(rcc_pkg::CAL_STAGE_DIV - 1 - rcc_pkg::CAL_SHORTEN);
      end
   end

   logic extra_done;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pre_cnt <= 8'h00;
         stage_cnt <= 8'h00;
         div256_tick <= 1'b0;
         second_tick <= 1'b0;
         extra_done <= 1'b0;
      end else begin
         div256_tick <= 1'b0;
         second_tick <= 1'b0;
         if (osc_edge && !stop_bit) begin
            if (pre_cnt >= pre_top) begin
               pre_cnt <= 8'h00;
               div256_tick <= 1'b1;
               if (corr_now && cal_pos && !extra_done) begin
                  extra_done <= 1'b1; // stage repeated
               end else begin
                  extra_done <= 1'b0;
                  stage_cnt <= stage_cnt + 8'h01;
                  if (stage_cnt == 8'hff) begin
                     second_tick <= 1'b1;
                  end
               end
            end else begin
               pre_cnt <= pre_cnt + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n || minute_tick) begin
         sec_in_min <= 6'h00;
      end else if (second_tick) begin
         sec_in_min <= sec_in_min + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // 512 Hz test source from raw oscillator, untouched by calibration
   logic [4:0] test_cnt;
   logic test_wave;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         test_cnt <= 5'h00;
         test_wave <= 1'b0;
      end else if (osc_edge) begin
         if (test_cnt == 5'(rcc_pkg::TEST_HALF - 1)) begin
            test_cnt <= 5'h00;
            test_wave <= ~test_wave;
         end else begin
            test_cnt <= test_cnt + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // battery check
   logic [31:0] check_cnt;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         batt_weak <= 1'b0;
         check_cnt <= 32'h0;
      end else if (ms_s[1]) begin
         if (pu_edge || check_cnt >= 32'(SEC_PER_CHECK - 1)) begin
            check_cnt <= 32'h0;
            batt_weak <= bl_s[1];
         end else if (second_tick) begin
            check_cnt <= check_cnt + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // shared pin select
   logic wd_to_pin, wd_active, test_on, next_low;
   assign wd_to_pin = ~watchdog[rcc_pkg::WD_STEER_BIT];
   assign wd_active = watchdog != rcc_pkg::ZERO_BYTE;
   assign test_on = !stop_bit && control[rcc_pkg::FREQ_TEST_BIT]
      && !alarm_en && (!wd_to_pin || !wd_active);

   always_comb begin
      if (irq_pending || (wd_timeout && wd_to_pin)) begin
         next_low = 1'b1;
      end else if (test_on) begin
         next_low = ~test_wave;
      end else if (!control[rcc_pkg::FREQ_TEST_BIT] && !alarm_en
                   && !wd_active) begin
         next_low = ~control[rcc_pkg::OUT_LEVEL_BIT];
      end else begin
         next_low = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         shared_irq_test_pin_oe <= 1'b0;
         shared_irq_test_pin_o <= 1'b0;
      end else begin
         shared_irq_test_pin_oe <= next_low;
         shared_irq_test_pin_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   correction_once_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (second_tick && !minute_tick) |=> !min_armed)
      else $error("correction armed past its second");
   no_cal_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cal_mag == 5'h00 && minute_tick) |=> !min_armed)
      else $error("correction armed with zero magnitude");
   write_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (desel_busy && wr && addr == rcc_pkg::ADDR_CONTROL && !pu_edge
       && !pd_edge) |=> $stable(control))
      else $error("write accepted while deselected");
   ft_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pd_edge |=> !control[rcc_pkg::FREQ_TEST_BIT])
      else $error("test bit survived power-down");
   wd_prio_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (wd_active && wd_to_pin) |-> !test_on)
      else $error("test output beat watchdog");
   irq_pin_a: assert property (@(posedge mclk) disable iff (!rst_n)
      irq_pending |=> shared_irq_test_pin_oe)
      else $error("pending interrupt not on pin");
   out_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (!irq_pending && !wd_timeout && !wd_active && !alarm_en
       && control == 8'h00) |=> shared_irq_test_pin_oe)
      else $error("output bit low not driven");
   century_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (century_rollover && cent_en && !wr) |=> cent_flag != $past(cent_flag))
      else $error("century flag missed rollover");
   batt_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !ms_s[1] |=> $stable(batt_weak))
      else $error("battery checked without supply");
   desel_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
      pu_edge |=> desel_busy ##1 deselected)
      else $error("deselect did not start");
endmodule // rcc_top
